// ### sim/fpu_stack_data_transfer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module fpu_stack_data_transfer_tb;
    import fpu_xfer_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        iv;
    issue_t      iss;
    logic [79:0] rd;
    int_flags_t  flg = '0;
    logic        inv_m = 1'b1;
    logic        den_m = 1'b1;
    logic        done, wv, ie, de, feat;
    fmt_t        wf;
    logic [79:0] wd, top_e;
    logic [2:0]  top;
    logic [7:0]  tag;
    int          errors = 0;
    int          n_compared = 0;
    int          cycles = 0;
    localparam logic [79:0] ONE  = 80'h3FFF_8000_0000_0000_0000;
    localparam logic [79:0] FIVE = 80'h4001_A000_0000_0000_0000;
    localparam logic [79:0] TINY = 80'h0001_8000_0000_0000_0001;
    localparam logic [79:0] P31  = 80'h401E_8000_0000_0000_0000;
    issue_source i_src (.mclk_i(mclk_i), .issue_valid_o(iv), .issue_o(iss), .mem_rd_data_o(rd));
    fpu_stack_data_transfer i_dut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .issue_valid_i(iv), .issue_i(iss),
        .mem_rd_data_i(rd), .int_flags_i(flg), .invalid_mask_i(inv_m), .denormal_mask_i(den_m),
        .done_o(done), .mem_wr_valid_o(wv), .mem_wr_fmt_o(wf), .mem_wr_data_o(wd),
        .invalid_exc_o(ie), .denormal_exc_o(de), .stack_top_o(top), .tag_o(tag),
        .stack_top_entry_o(top_e), .cond_move_feature_o(feat));
    initial begin
        forever #2.5 mclk_i = ~mclk_i;
    end
    // ----------------------------------------
    // Checking and closing
    // ----------------------------------------
    task automatic chk(input logic ok, input string m);
        n_compared++;
        if (ok !== 1'b1) begin
            errors++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task automatic complete_run();
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // Ceiling sized well above the few dozen cycles the tests need
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            complete_run();
        end
    end
    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (2) @(negedge mclk_i);
        rst_n_i = 1'b1;
        chk(feat === 1'b1, "feature bit");
        i_src.send(8'hDD, OP_LOAD_PUSH, FMT_DOUBLE, 1'b0, 3'h0, COND_BELOW, 80'h3FF0_0000_0000_0000);
        chk(done === 1'b1 && top === 3'h7 && tag === 8'h80, "push wrap");
        chk(top_e === ONE, "double load");
        i_src.send(8'hDB, OP_LOAD_PUSH, FMT_INT32, 1'b0, 3'h0, COND_BELOW, 80'h5);
        chk(top === 3'h6 && tag === 8'hC0 && top_e === FIVE, "int load");
        i_src.send(8'hD9, OP_EXCHANGE, FMT_EXT, 1'b1, 3'h1, COND_BELOW, 80'h0);
        chk(top_e === ONE && top === 3'h6, "exchange");
        $display("load and exchange test done");
        i_src.send(8'hDA, OP_COND_MOVE, FMT_EXT, 1'b1, 3'h1, COND_BELOW, 80'h0);
        chk(top_e === ONE, "false move");
        i_src.send(8'hDB, OP_COND_MOVE, FMT_EXT, 1'b1, 3'h1, COND_ORDERED, 80'h0);
        chk(top_e === FIVE, "true move");
        $display("conditional move test done");
        i_src.send(8'hDF, OP_STORE_POP, FMT_INT16, 1'b0, 3'h0, COND_BELOW, 80'h0);
        chk(wv === 1'b1 && wf === FMT_INT16 && wd === 80'h5, "int store");
        chk(top === 3'h7 && tag === 8'h80, "pop");
        inv_m = 1'b0;
        i_src.send(8'hDB, OP_LOAD_PUSH, FMT_EXT, 1'b0, 3'h0, COND_BELOW, 80'h7FFF_0000_0000_0000_0000);
        chk(ie === 1'b1 && top === 3'h7 && tag === 8'h80, "pseudo infinity");
        inv_m = 1'b1;
        i_src.send(8'hDB, OP_LOAD_PUSH, FMT_EXT, 1'b0, 3'h0, COND_BELOW, 80'h0000_8000_0000_0000_0001);
        chk(de === 1'b1 && top === 3'h6, "pseudo denormal");
        chk(top_e === TINY, "no pseudo denormal kept");
        i_src.send(8'h90, OP_LOAD_PUSH, FMT_EXT, 1'b0, 3'h0, COND_BELOW, 80'h0);
        chk(done === 1'b0 && top === 3'h6, "foreign opcode");
        $display("screening test done");
        i_src.send(8'hDD, OP_STORE_POP, FMT_EXT, 1'b1, 3'h1, COND_BELOW, 80'h0);
        chk(wv === 1'b0 && top === 3'h7 && tag === 8'h80 && top_e === TINY, "register store pop");
        i_src.send(8'hDD, OP_LOAD_PUSH, FMT_DOUBLE, 1'b0, 3'h0, COND_BELOW, 80'h41E0_0000_0000_0000);
        chk(top === 3'h6 && top_e === P31, "large double load");
        i_src.send(8'hDD, OP_STORE, FMT_DOUBLE, 1'b0, 3'h0, COND_BELOW, 80'h0);
        chk(wv === 1'b1 && wf === FMT_DOUBLE && top === 3'h6, "double store strobe");
        chk(wd === 80'h41E0_0000_0000_0000, "double store data");
        i_src.send(8'hDB, OP_STORE_POP, FMT_INT32, 1'b0, 3'h0, COND_BELOW, 80'h0);
        chk(wv === 1'b1 && ie === 1'b1 && wd === 80'h8000_0000, "integer indefinite");
        chk(top === 3'h7 && tag === 8'h80, "store pop after invalid");
        i_src.send(8'hDF, OP_LOAD_PUSH, FMT_BCD, 1'b0, 3'h0, COND_BELOW, 80'h25);
        chk(top === 3'h6 && top_e === 80'h4003_C800_0000_0000_0000, "decimal load");
        i_src.send(8'hDF, OP_STORE_POP, FMT_BCD, 1'b0, 3'h0, COND_BELOW, 80'h0);
        chk(wv === 1'b1 && wf === FMT_BCD && wd === 80'h25 && top === 3'h7, "decimal store pop");
        $display("store test done");
        complete_run();
    end
endmodule
`default_nettype wire

// ### sim/issue_source.sv
`timescale 1ns/10ps
`default_nettype none
module issue_source
    import fpu_xfer_pkg::*;
(
    input  wire logic   mclk_i,
    output logic        issue_valid_o,
    output issue_t      issue_o,
    output logic [79:0] mem_rd_data_o
);
    initial begin
        issue_valid_o = 1'b0;
        issue_o       = '0;
        mem_rd_data_o = '0;
    end
    // ----------------------------------------
    // One request per call, launched at the falling edge
    // ----------------------------------------
    // Operand is not held after its cycle, so a late sample sees inverted data
    task automatic send(input logic [7:0] opc, input op_t op, input fmt_t fmt, input logic r,
                        input logic [2:0] sti, input cond_t c, input logic [79:0] d);
        @(negedge mclk_i);
        issue_o       = '{opc, op, fmt, r, sti, c};
        mem_rd_data_o = d;
        issue_valid_o = 1'b1;
        @(negedge mclk_i);
        issue_valid_o = 1'b0;
        mem_rd_data_o = ~d;
    endtask
endmodule
`default_nettype wire

// ### verilog/fpu_operand_screen.sv
`timescale 1ns/10ps
`default_nettype none
module fpu_operand_screen
    import fpu_xfer_pkg::*;
(
    input  wire logic [79:0] value_i,
    output opnd_class_t      class_o
);

    wire logic [14:0] exp_w     = value_i[78:64];
    wire logic        int_bit   = value_i[INT_POS];
    wire logic        frac_nz   = |value_i[62:0];
    wire logic        exp_zero  = (exp_w == 15'h0000);
    wire logic        exp_ones  = (exp_w == EXP_MAX);

    // Classes by exponent, explicit integer bit and fraction; see [RULE4]
    assign class_o.pseudo_denormal = exp_zero & int_bit;
    assign class_o.pseudo_inf      = exp_ones & ~int_bit & ~frac_nz;
    assign class_o.pseudo_nan      = exp_ones & ~int_bit & frac_nz;
    assign class_o.unnormal        = ~exp_zero & ~exp_ones & ~int_bit;
    assign class_o.denormal        = exp_zero & ~int_bit & frac_nz;

endmodule
`default_nettype wire

// ### verilog/fpu_stack_data_transfer.sv
`timescale 1ns/10ps
`default_nettype none
// Function
// [RULE1] Pseudo-NaN, pseudo-infinity or unnormal operand raises invalid operation.
// [RULE2] No pseudo-denormal is ever written to a register or memory.
// [RULE3] Pseudo-denormal operand is used as a denormal and raises denormal.
// [RULE4] Classify by sign, 15-bit exponent, integer bit and 63-bit fraction.
// [RULE5] Instruction is floating only when first opcode byte is D8 to DF.
// [RULE6] Register operands are offsets from top; no immediate operands.
// [RULE7] Float load pushes converted memory value or a copy of an entry.
// [RULE8] Integer and packed-decimal loads convert to extended and push.
// [RULE9] Float and integer stores write converted top value to memory.
// [RULE10] Pop marks top entry empty and increments the stack pointer.
// [RULE11] Store-and-pop variants write memory first, then pop once.
// [RULE12] Float store-and-pop may copy top into a selected entry, then pop.
// [RULE13] Exchange swaps the selected entry with the top entry.
// [RULE14] Conditional move copies selected entry to top only when true.
// [RULE15] Conditions decode from carry, zero and parity flags as tabled.
// [RULE16] A feature bit reports that conditional moves exist.
// [RULE17] Masked invalid integer store writes the most negative value; code only does so out of range, an empty top stores its old entry.
// [RULE18] Masked-denormal single or double source is normalised on load.
// [RULE19] Push decrements pointer modulo eight, writes, marks entry valid.
// [RULE20] Stack pointer wraps modulo eight both ways.
module fpu_stack_data_transfer
    import fpu_xfer_pkg::*;
(
    input  wire logic        mclk_i,
    input  wire logic        rst_n_i,
    input  wire logic        issue_valid_i,
    input  wire issue_t      issue_i,
    input  wire logic [79:0] mem_rd_data_i,
    input  wire int_flags_t  int_flags_i,
    input  wire logic        invalid_mask_i,
    input  wire logic        denormal_mask_i,
    output logic             done_o,
    output logic             mem_wr_valid_o,
    output fmt_t             mem_wr_fmt_o,
    output logic [79:0]      mem_wr_data_o,
    output logic             invalid_exc_o,
    output logic             denormal_exc_o,
    output logic [2:0]       stack_top_o,
    output logic [7:0]       tag_o,
    output logic [79:0]      stack_top_entry_o,
    output logic             cond_move_feature_o
);

    // ----------------------------------------
    // Conversion helpers
    // ----------------------------------------
    function automatic logic [5:0] lead_zeros(input logic [63:0] v);
        lead_zeros = 6'h00;
        for (int i = 0; i < 64; i++) begin
            if (v[i]) begin
                lead_zeros = 6'(63 - i);
            end
        end
    endfunction

    // Denormals are always normalised; unmasked ones never reach the stack
    function automatic logic [79:0] widen_fp(input logic s, input logic [10:0] e, input logic e_max,
                                             input logic [51:0] f, input logic [14:0] rebias);
        logic [63:0] m;
        logic [5:0]  sh;
        m  = {1'b0, f, 11'h000};
        sh = lead_zeros(m);
        if (e_max) begin
            widen_fp = {s, EXP_MAX, 1'b1, f, 11'h000};
        end else if (e == 11'h000 && f == 52'h0) begin
            widen_fp = {s, 79'h0};
        end else if (e == 11'h000) begin
            widen_fp = {s, rebias + 15'h0001 - {9'h000, sh}, m << sh}; // see [RULE18]
        end else begin
            widen_fp = {s, {4'h0, e} + rebias, 1'b1, f, 11'h000};
        end
    endfunction

    function automatic logic [79:0] widen_int(input logic s, input logic [63:0] mag);
        logic [5:0] sh;
        sh = lead_zeros(mag);
        if (mag == 64'h0) begin
            widen_int = 80'h0;
        end else begin
            widen_int = {s, EXT_INT_TOP - {9'h000, sh}, mag << sh};
        end
    endfunction

    function automatic logic [63:0] bcd_to_bin(input logic [71:0] d);
        logic [63:0] acc;
        acc = 64'h0;
        for (int i = 17; i >= 0; i--) begin
            acc = (acc << 3) + (acc << 1) + {60'h0, d[i*4 +: 4]};
        end
        return acc;
    endfunction

    function automatic logic [71:0] bin_to_bcd(input logic [63:0] b);
        logic [71:0] d;
        d = 72'h0;
        for (int i = 63; i >= 0; i--) begin
            for (int k = 0; k < 18; k++) begin
                if (d[k*4 +: 4] > 4'h4) begin
                    d[k*4 +: 4] = d[k*4 +: 4] + 4'h3;
                end
            end
            d = {d[70:0], b[i]};
        end
        return d;
    endfunction

    // Truncates toward zero; returns {out of range, magnitude}
    function automatic logic [64:0] ext_to_mag(input logic [79:0] v, input logic [63:0] max_mag);
        logic [14:0] e;
        logic [63:0] mag;
        e   = v[78:64];
        mag = 64'h0;
        if (e >= EXT_BIAS && e <= EXT_INT_TOP) begin
            mag = v[63:0] >> 6'(EXT_INT_TOP - e);
        end
        return {(e > EXT_INT_TOP) || (mag > max_mag), mag};
    endfunction

    // Truncates the fraction; out-of-range results go to infinity or signed zero
    function automatic logic [63:0] narrow_fp(input logic [79:0] v, input logic dbl);
        logic [14:0] e;
        logic [10:0] eo;
        e  = v[78:64];
        eo = 11'(e - (dbl ? DBL_REBIAS : SGL_REBIAS));
        if (e == EXP_MAX || e > (dbl ? DBL_EXP_HI : SGL_EXP_HI)) begin
            narrow_fp = dbl ? {v[79], 11'h7FF, v[62:11] & {52{e == EXP_MAX}}}
                            : {32'h0, v[79], 8'hFF, v[62:40] & {23{e == EXP_MAX}}};
        end else if (e < (dbl ? DBL_EXP_LO : SGL_EXP_LO)) begin
            narrow_fp = dbl ? {v[79], 63'h0} : {32'h0, v[79], 31'h0};
        end else begin
            narrow_fp = dbl ? {v[79], eo, v[62:11]} : {32'h0, v[79], eo[7:0], v[62:40]};
        end
    endfunction

    function automatic logic [79:0] canon(input logic [79:0] v);
        canon = v;
        if (v[78:64] == 15'h0000 && v[INT_POS]) begin
            canon[78:64] = 15'h0001; // see [RULE2]
        end
    endfunction

    function automatic logic cond_true(input cond_t c, input int_flags_t f);
        case (c) // see [RULE15]
            COND_BELOW:       cond_true = f.carry_flag;
            COND_NOT_BELOW:   cond_true = ~f.carry_flag;
            COND_EQUAL:       cond_true = f.zero_flag;
            COND_NOT_EQUAL:   cond_true = ~f.zero_flag;
            COND_BELOW_EQUAL: cond_true = f.carry_flag | f.zero_flag;
            COND_ABOVE:       cond_true = ~(f.carry_flag | f.zero_flag);
            COND_UNORDERED:   cond_true = f.parity_flag;
            COND_ORDERED:     cond_true = ~f.parity_flag;
            default:          cond_true = 1'b0;
        endcase
    endfunction

    // ----------------------------------------
    // Stack state
    // ----------------------------------------
    logic [79:0] entry_reg [STACK_DEPTH];
    logic [79:0] entry_next [STACK_DEPTH];
    logic [7:0]  tag_reg;
    logic [7:0]  tag_next;
    logic [2:0]  top_reg;
    logic [2:0]  top_next;

    // ----------------------------------------
    // Decode and operand selection
    // ----------------------------------------
    wire logic is_float = (issue_i.opcode >= FLOAT_OPC_LO) && (issue_i.opcode <= FLOAT_OPC_HI); // see [RULE5]
    wire logic go       = issue_valid_i & is_float;
    wire op_t  op       = issue_i.op;
    wire fmt_t fmt      = issue_i.fmt;
    wire logic reg_opnd = issue_i.reg_opnd;

    wire logic [2:0]  sel_idx  = 3'(top_reg + issue_i.sti); // see [RULE6]
    wire logic [2:0]  push_idx = 3'(top_reg - 3'h1);        // see [RULE20]
    wire logic [2:0]  pop_idx  = 3'(top_reg + 3'h1);
    wire logic [79:0] top_val  = entry_reg[top_reg];
    wire logic [79:0] sel_val  = entry_reg[sel_idx];

    wire logic is_load  = go && op == OP_LOAD_PUSH;
    wire logic mem_load = is_load & ~reg_opnd;
    wire logic is_store = go && (op == OP_STORE || op == OP_STORE_POP);
    wire logic mem_st   = is_store & ~reg_opnd;
    wire logic is_pop   = go && op == OP_STORE_POP;
    wire logic is_xchg  = go && op == OP_EXCHANGE;
    wire logic is_cmov  = go && op == OP_COND_MOVE;
    wire logic cmov_hit = cond_true(issue_i.cond, int_flags_i);
    wire logic int_fmt  = fmt == FMT_INT16 || fmt == FMT_INT32 || fmt == FMT_INT64;

    // ----------------------------------------
    // Memory operand conversion to extended
    // ----------------------------------------
    wire logic [31:0] raw_s    = mem_rd_data_i[31:0];
    wire logic [63:0] raw_d    = mem_rd_data_i[63:0];
    wire logic [63:0] raw_int  = (fmt == FMT_INT16) ? {{48{mem_rd_data_i[15]}}, mem_rd_data_i[15:0]} :
                                 (fmt == FMT_INT32) ? {{32{mem_rd_data_i[31]}}, mem_rd_data_i[31:0]} : raw_d;
    wire logic [63:0] int_mag  = raw_int[63] ? 64'(-raw_int) : raw_int;
    wire logic [63:0] bcd_mag  = bcd_to_bin(mem_rd_data_i[71:0]);
    wire logic        src_den  = (fmt == FMT_SINGLE && raw_s[30:23] == 8'h00 && raw_s[22:0] != 23'h0) ||
                                 (fmt == FMT_DOUBLE && raw_d[62:52] == 11'h000 && raw_d[51:0] != 52'h0);
    logic [79:0] mem_conv;

    always_comb begin
        case (fmt) // see [RULE7] see [RULE8]
            FMT_SINGLE: mem_conv = widen_fp(raw_s[31], {3'h0, raw_s[30:23]}, &raw_s[30:23],
                                            {raw_s[22:0], 29'h0}, SGL_REBIAS);
            FMT_DOUBLE: mem_conv = widen_fp(raw_d[63], raw_d[62:52], &raw_d[62:52], raw_d[51:0], DBL_REBIAS);
            FMT_EXT:    mem_conv = mem_rd_data_i;
            FMT_BCD:    mem_conv = widen_int(mem_rd_data_i[SIGN_POS], bcd_mag);
            default:    mem_conv = widen_int(raw_int[63], int_mag);
        endcase
    end

    // ----------------------------------------
    // Operand screening and exceptions
    // ----------------------------------------
    opnd_class_t cls;
    wire logic [79:0] screen_val = mem_load ? ((fmt == FMT_EXT) ? mem_rd_data_i : 80'h0)
                                            : (is_load ? sel_val : top_val);
    wire logic        screen_en  = is_load | is_store;
    wire logic        unsup      = screen_en & (cls.pseudo_nan | cls.pseudo_inf | cls.unnormal);

    fpu_operand_screen u_screen (
        .value_i (screen_val),
        .class_o (cls)
    );

    // Store conversion limits per destination format
    // For integer formats the negative side reaches one step further, down to the most negative value
    wire logic [63:0] lim_mag  = (fmt == FMT_INT16) ? 64'h0000_0000_0000_7FFF :
                                 (fmt == FMT_INT32) ? 64'h0000_0000_7FFF_FFFF : 64'h7FFF_FFFF_FFFF_FFFF;
    wire logic [63:0] max_mag  = (fmt == FMT_BCD) ? BCD_MAX_MAG : lim_mag + {63'h0, top_val[SIGN_POS]};
    wire logic [64:0] st_conv  = ext_to_mag(top_val, max_mag);
    wire logic        conv_bad = mem_st & (int_fmt | fmt == FMT_BCD) & st_conv[64];

    wire logic stack_fault = (is_load & reg_opnd & ~tag_reg[sel_idx]) | (is_load & tag_reg[push_idx]) |
                             (is_store & ~tag_reg[top_reg]) |
                             ((is_xchg | is_cmov) & ~(tag_reg[top_reg] & tag_reg[sel_idx]));
    wire logic inv_raise   = unsup | stack_fault | conv_bad;                                  // see [RULE1]
    wire logic den_raise   = screen_en & cls.pseudo_denormal | is_load & cls.denormal |
                             mem_load & src_den;                                              // see [RULE3]
    wire logic blocked     = (inv_raise & ~invalid_mask_i) | (den_raise & ~denormal_mask_i);
    wire logic exec        = go & ~blocked;

    // ----------------------------------------
    // Store data
    // ----------------------------------------
    logic [63:0] int_val;
    logic [79:0] st_data;

    always_comb begin
        int_val = top_val[SIGN_POS] ? 64'(-st_conv[63:0]) : st_conv[63:0];
        case (fmt) // see [RULE9]
            FMT_SINGLE: st_data = {16'h0, narrow_fp(top_val, 1'b0)};
            FMT_DOUBLE: st_data = {16'h0, narrow_fp(top_val, 1'b1)};
            FMT_EXT:    st_data = canon(top_val);
            FMT_INT16:  st_data = {64'h0, conv_bad ? 16'h8000 : int_val[15:0]};           // see [RULE17]
            FMT_INT32:  st_data = {48'h0, conv_bad ? 32'h8000_0000 : int_val[31:0]};      // see [RULE17]
            FMT_BCD:    st_data = conv_bad ? BCD_INDEF : {top_val[SIGN_POS], 7'h00, bin_to_bcd(st_conv[63:0])};
            default:    st_data = {16'h0, conv_bad ? 64'h8000_0000_0000_0000 : int_val};  // see [RULE17]
        endcase
    end

    // ----------------------------------------
    // Stack update
    // ----------------------------------------
    wire logic        wr_a_en  = exec & (is_load | (is_store & reg_opnd) | is_xchg | (is_cmov & cmov_hit));
    wire logic [2:0]  wr_a_idx = is_load ? push_idx : ((is_store & reg_opnd) ? sel_idx : top_reg);
    wire logic [79:0] wr_a_raw = is_load ? (inv_raise ? QNAN_INDEF : (reg_opnd ? sel_val : mem_conv))
                                         : ((is_store & reg_opnd) ? top_val : sel_val); // see [RULE12] see [RULE14]
    wire logic [79:0] wr_a_val = canon(wr_a_raw);
    wire logic        wr_b_en  = exec & is_xchg;
    wire logic        do_pop   = exec & is_pop;                                        // see [RULE11]

    assign top_next = (exec & is_load) ? push_idx : (do_pop ? pop_idx : top_reg);   // see [RULE19] see [RULE10]

    generate
        for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_entry
            assign entry_next[i] = (wr_a_en && wr_a_idx == 3'(i)) ? wr_a_val :
                                   (wr_b_en && sel_idx == 3'(i)) ? top_val : entry_reg[i]; // see [RULE13]
            assign tag_next[i]   = (do_pop && top_reg == 3'(i)) ? 1'b0 :
                                   (wr_a_en && wr_a_idx == 3'(i)) ? 1'b1 : tag_reg[i];  // see [RULE10] see [RULE19]

            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    entry_reg[i] <= 80'h0;
                end else begin
                    entry_reg[i] <= entry_next[i];
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tag_reg <= 8'h00;
            top_reg <= 3'h0;
        end else begin
            tag_reg <= tag_next;
            top_reg <= top_next;
        end
    end

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o              <= 1'b0;
            mem_wr_valid_o      <= 1'b0;
            mem_wr_fmt_o        <= FMT_SINGLE;
            mem_wr_data_o       <= 80'h0;
            invalid_exc_o       <= 1'b0;
            denormal_exc_o      <= 1'b0;
            stack_top_entry_o   <= 80'h0;
            cond_move_feature_o <= CMOV_FEATURE; // see [RULE16]
        end else begin
            done_o              <= go;
            mem_wr_valid_o      <= exec & mem_st;
            mem_wr_fmt_o        <= fmt;
            mem_wr_data_o       <= st_data;
            invalid_exc_o       <= go & inv_raise;
            denormal_exc_o      <= go & den_raise;
            stack_top_entry_o   <= entry_next[top_next];
            cond_move_feature_o <= CMOV_FEATURE;
        end
    end

    assign stack_top_o = top_reg;
    assign tag_o       = tag_reg;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    chk_push_top: assert property (exec & is_load |=> top_reg == $past(push_idx) && tag_o[top_reg]) // see [RULE19]
        else $error("push did not move top down and mark it valid");
    chk_pop_top: assert property (do_pop |=> top_reg == 3'($past(top_reg) + 3'h1) && !tag_o[$past(top_reg)]) // see [RULE10]
        else $error("pop did not free top and advance pointer");
    chk_unsup_inval: assert property (unsup |=> invalid_exc_o) // see [RULE1]
        else $error("unsupported encoding did not raise invalid");
    chk_pseudo_den: assert property (go & screen_en & cls.pseudo_denormal |=> denormal_exc_o) // see [RULE3]
        else $error("pseudo-denormal did not raise denormal");
    chk_no_pseudo_out: assert property (mem_wr_valid_o && mem_wr_fmt_o == FMT_EXT |->
                                        !(mem_wr_data_o[78:64] == 15'h0000 && mem_wr_data_o[63])) // see [RULE2]
        else $error("pseudo-denormal written to memory");
    chk_escape_range: assert property (issue_valid_i & !is_float |=> !done_o && !mem_wr_valid_o) // see [RULE5]
        else $error("non-floating opcode was executed");
    chk_int_indef: assert property (exec & conv_bad & fmt == FMT_INT32 |=>
                                    mem_wr_valid_o && mem_wr_data_o[31:0] == 32'h8000_0000) // see [RULE17]
        else $error("masked invalid integer store lacks indefinite");
    chk_cmov_hold: assert property (is_cmov & !cmov_hit |=> stack_top_entry_o == $past(top_val)) // see [RULE14]
        else $error("false conditional move changed top entry");
    chk_xchg_swap: assert property (exec & is_xchg |=> entry_reg[$past(top_reg)] == $past(sel_val) &&
                                    entry_reg[$past(sel_idx)] == $past(top_val)) // see [RULE13]
        else $error("exchange did not swap entries");
    chk_feature_bit: assert property (done_o |-> cond_move_feature_o) // see [RULE16]
        else $error("conditional move feature bit not set");

    cov_load_push: cover property (exec & is_load ##1 done_o);
    cov_store_pop: cover property (do_pop & mem_st);
    cov_exchange: cover property (exec & is_xchg);
    cov_cmov_taken: cover property (exec & is_cmov & cmov_hit);

endmodule
`default_nettype wire

// ### verilog/fpu_xfer_pkg.sv
package fpu_xfer_pkg;

    // ----------------------------------------
    // Opcode class and stack geometry
    // ----------------------------------------
    localparam logic [7:0]  FLOAT_OPC_LO = 8'hD8;
    localparam logic [7:0]  FLOAT_OPC_HI = 8'hDF;
    localparam int          STACK_DEPTH  = 8;
    localparam logic        CMOV_FEATURE = 1'b1;

    // ----------------------------------------
    // Extended format fields and exponent limits
    // ----------------------------------------
    localparam int          SIGN_POS     = 79;
    localparam int          INT_POS      = 63;
    localparam logic [14:0] EXP_MAX      = 15'h7FFF;
    localparam logic [14:0] EXT_BIAS     = 15'h3FFF;
    localparam logic [14:0] EXT_INT_TOP  = 15'h403E;
    localparam logic [14:0] SGL_REBIAS   = 15'h3F80;
    localparam logic [14:0] DBL_REBIAS   = 15'h3C00;
    localparam logic [14:0] SGL_EXP_LO   = 15'h3F81;
    localparam logic [14:0] SGL_EXP_HI   = 15'h407E;
    localparam logic [14:0] DBL_EXP_LO   = 15'h3C01;
    localparam logic [14:0] DBL_EXP_HI   = 15'h43FE;
    localparam logic [79:0] QNAN_INDEF   = 80'hFFFF_C000_0000_0000_0000;
    localparam logic [79:0] BCD_INDEF    = 80'hFFFF_C000_0000_0000_0000;
    localparam logic [63:0] BCD_MAX_MAG  = 64'h0DE0_B6B3_A763_FFFF;

    // ----------------------------------------
    // Operations, formats and conditions
    // ----------------------------------------
    typedef enum logic [2:0] {
        OP_NONE, OP_LOAD_PUSH, OP_STORE, OP_STORE_POP, OP_EXCHANGE, OP_COND_MOVE
    } op_t;
    typedef enum logic [2:0] {
        FMT_SINGLE, FMT_DOUBLE, FMT_EXT, FMT_INT16, FMT_INT32, FMT_INT64, FMT_BCD
    } fmt_t;
    typedef enum logic [2:0] {
        COND_BELOW, COND_NOT_BELOW, COND_EQUAL, COND_NOT_EQUAL,
        COND_BELOW_EQUAL, COND_ABOVE, COND_UNORDERED, COND_ORDERED
    } cond_t;

    typedef struct packed {
        logic [7:0] opcode;
        op_t        op;
        fmt_t       fmt;
        logic       reg_opnd;
        logic [2:0] sti;
        cond_t      cond;
    } issue_t;

    typedef struct packed {
        logic carry_flag;
        logic zero_flag;
        logic parity_flag;
    } int_flags_t;

    typedef struct packed {
        logic pseudo_nan;
        logic pseudo_inf;
        logic unnormal;
        logic pseudo_denormal;
        logic denormal;
    } opnd_class_t;

endpackage
